// [rtl/srwc_pkg.sv]
package srwc_pkg;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_RESET_CAUSE = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_SYS_OPTIONS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_POWER_MON = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_IRQ_PENDING = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_WD_COUNT = 8'h10;

  // ----------------------------------------
  // Reset cause bits
  // ----------------------------------------
  localparam int CAUSE_POR = 7;
  localparam int CAUSE_PIN = 6;
  localparam int CAUSE_WD = 5;
  localparam int CAUSE_BAD_OP = 4;
  localparam int CAUSE_BAD_ADDR = 3;
  localparam int CAUSE_LV = 1;

  // ----------------------------------------
  // Options register bits and defaults
  // ----------------------------------------
  localparam int OPT_WD_EN = 0;
  localparam int OPT_WD_LONG = 1;
  localparam int OPT_PIN_EN = 2;
  localparam int OPT_STOP_ALLOW = 3;
  localparam int OPT_LOCKED = 7;
  localparam logic DEF_WD_EN = 1'b1;
  localparam logic DEF_WD_LONG = 1'b1;
  localparam logic DEF_PIN_EN = 1'b1;
  localparam logic DEF_STOP_ALLOW = 1'b0;

  // ----------------------------------------
  // Power monitor bits and defaults
  // ----------------------------------------
  localparam int PM_LV_EN = 0;
  localparam int PM_LV_STOP_EN = 1;
  localparam int PM_LV_RST_EN = 2;
  localparam int PM_LV_IRQ_EN = 3;
  localparam int PM_FLAG = 4;
  localparam int PM_ACK = 5;
  localparam logic DEF_LV_EN = 1'b1;
  localparam logic DEF_LV_STOP_EN = 1'b0;
  localparam logic DEF_LV_RST_EN = 1'b1;
  localparam logic DEF_LV_IRQ_EN = 1'b0;

  // ----------------------------------------
  // Pending register: one bit per module
  // ----------------------------------------
  localparam int NUM_MOD = 5;
  localparam int EXT_MOD = 4;
  localparam int PEND_LV = 4;

  // ----------------------------------------
  // Boot fetch and watchdog limits
  // ----------------------------------------
  localparam logic [13:0] BOOT_FETCH_ADDR = 14'h3ffd;
  localparam logic [7:0] BOOT_JUMP_OPCODE = 8'hbc;
  localparam int WD_W = 8;
  localparam logic [WD_W-1:0] WD_SHORT_LAST = 8'h1f;
  localparam logic [WD_W-1:0] WD_LONG_LAST = 8'hff;
  localparam logic [WD_W-1:0] WD_ONE = 8'h01;

  typedef enum logic [0:0] {
    SRWC_RUN = 1'b0,
    SRWC_HOLD = 1'b1
  } srwc_state_e;

  typedef struct packed {
    srwc_state_e state;
    logic hold_lv;
    logic wreq;
    logic [31:0] rdata;
    logic [7:0] cause;
    logic wd_en;
    logic wd_long;
    logic pin_en;
    logic stop_allow;
    logic locked;
    logic lv_en;
    logic lv_stop_en;
    logic lv_rst_en;
    logic lv_irq_en;
    logic lv_flag;
    logic [WD_W-1:0] wd_count;
    logic tick_q;
    logic stop_q;
    logic sys_rst;
    logic periph_off;
    logic pins_hiz;
    logic wake;
    logic lv_irq;
    logic lv_active;
    logic [13:0] boot_addr;
    logic [7:0] boot_op;
  } srwc_regs_s;

endpackage

// [rtl/srwc_top.sv]
`timescale 1ns/1ns
`default_nettype none
module srwc_top import srwc_pkg::*; (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic [ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic PIN_RESET_N,
  input wire logic POWER_ON_DETECT,
  input wire logic LOW_VOLTAGE_DETECT,
  input wire logic BAD_OPCODE,
  input wire logic BAD_ADDRESS,
  input wire logic STOP_EXECUTED,
  input wire logic BACKGROUND_EXECUTED,
  input wire logic DEBUG_MODE_ALLOW,
  input wire logic DEBUG_FORCED_RESET_CMD,
  input wire logic DEBUG_MODE,
  input wire logic STOP_MODE,
  input wire logic TICK_1KHZ,
  input wire logic [EXT_MOD-1:0] MODULE_FLAGS,
  input wire logic [EXT_MOD-1:0] MODULE_IRQ_EN,
  output logic SYSTEM_RESET,
  output logic PERIPH_DISABLE,
  output logic PINS_FORCE_HIZ,
  output logic [13:0] BOOT_ADDR,
  output logic [7:0] BOOT_OPCODE,
  output logic WAKE_CPU,
  output logic LOW_VOLTAGE_IRQ,
  output logic LOW_VOLTAGE_DETECT_ACTIVE
);

  srwc_regs_s r;
  srwc_regs_s n;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [WD_W-1:0] wd_last(input logic long_sel);
    wd_last = long_sel ? WD_LONG_LAST : WD_SHORT_LAST;
  endfunction

  function automatic logic lv_on(input logic en, input logic stop_en, input logic in_stop);
    lv_on = en & (~in_stop | stop_en);
  endfunction

  logic acc_wr;
  logic acc_rd;
  logic tick_edge;
  logic wd_over;
  logic lv_trip;
  logic src_pin;
  logic src_wd;
  logic src_bad_op;
  logic src_lv;
  logic any_src;
  logic [NUM_MOD-1:0] pending;

  always_comb begin
    // Writes land at the edge where waitrequest is seen low
    acc_wr = AVS_WRITE & ~r.wreq;
    acc_rd = AVS_READ & r.wreq;
    tick_edge = TICK_1KHZ & ~r.tick_q;
    wd_over = r.wd_en & tick_edge & ~DEBUG_MODE & ~STOP_MODE
              & (r.wd_count == wd_last(r.wd_long));
    lv_trip = lv_on(r.lv_en, r.lv_stop_en, STOP_MODE) & LOW_VOLTAGE_DETECT;
    src_pin = r.pin_en & ~PIN_RESET_N;
    src_wd = wd_over;
    src_bad_op = BAD_OPCODE | (STOP_EXECUTED & ~r.stop_allow)
                 | (BACKGROUND_EXECUTED & ~DEBUG_MODE_ALLOW);
    src_lv = lv_trip & r.lv_rst_en;
    any_src = POWER_ON_DETECT | src_pin | src_wd | src_bad_op | BAD_ADDRESS
              | src_lv | DEBUG_FORCED_RESET_CMD;
    pending = {r.lv_flag, MODULE_FLAGS};
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    n = r;
    n.tick_q = TICK_1KHZ;
    n.stop_q = STOP_MODE;
    n.boot_addr = BOOT_FETCH_ADDR;
    n.boot_op = BOOT_JUMP_OPCODE;
    n.lv_active = lv_on(r.lv_en, r.lv_stop_en, STOP_MODE);
    // Avalon slave: one wait cycle, then answer
    n.wreq = ~((AVS_READ | AVS_WRITE) & r.wreq);
    if (acc_rd) begin
      case (AVS_ADDRESS)
        OFS_RESET_CAUSE: n.rdata = {24'h000000, r.cause};
        OFS_SYS_OPTIONS: begin
          n.rdata = 32'h00000000;
          n.rdata[OPT_WD_EN] = r.wd_en;
          n.rdata[OPT_WD_LONG] = r.wd_long;
          n.rdata[OPT_PIN_EN] = r.pin_en;
          n.rdata[OPT_STOP_ALLOW] = r.stop_allow;
          n.rdata[OPT_LOCKED] = r.locked;
        end
        OFS_POWER_MON: begin
          n.rdata = 32'h00000000;
          n.rdata[PM_LV_EN] = r.lv_en;
          n.rdata[PM_LV_STOP_EN] = r.lv_stop_en;
          n.rdata[PM_LV_RST_EN] = r.lv_rst_en;
          n.rdata[PM_LV_IRQ_EN] = r.lv_irq_en;
          n.rdata[PM_FLAG] = r.lv_flag;
        end
        OFS_IRQ_PENDING: n.rdata = {27'h0000000, pending};
        OFS_WD_COUNT: n.rdata = {24'h000000, r.wd_count};
        default: n.rdata = 32'h00000000;
      endcase
    end
    // Watchdog counter
    if (tick_edge & r.wd_en & ~DEBUG_MODE) begin
      n.wd_count = r.wd_count + WD_ONE;
    end
    if (acc_wr && AVS_ADDRESS == OFS_RESET_CAUSE) begin
      n.wd_count = '0;
    end
    if (acc_wr && AVS_ADDRESS == OFS_SYS_OPTIONS && !r.locked) begin
      n.wd_en = AVS_WRITEDATA[OPT_WD_EN];
      n.wd_long = AVS_WRITEDATA[OPT_WD_LONG];
      n.pin_en = AVS_WRITEDATA[OPT_PIN_EN];
      n.stop_allow = AVS_WRITEDATA[OPT_STOP_ALLOW];
      n.locked = 1'b1;
      n.wd_count = '0;
    end
    if (STOP_MODE) begin
      n.wd_count = '0;
    end
    // Power monitor
    if (acc_wr && AVS_ADDRESS == OFS_POWER_MON) begin
      n.lv_en = AVS_WRITEDATA[PM_LV_EN];
      n.lv_stop_en = AVS_WRITEDATA[PM_LV_STOP_EN];
      n.lv_rst_en = AVS_WRITEDATA[PM_LV_RST_EN];
      n.lv_irq_en = AVS_WRITEDATA[PM_LV_IRQ_EN];
      if (AVS_WRITEDATA[PM_ACK]) begin
        n.lv_flag = 1'b0;
      end
    end
    if (lv_trip & ~r.lv_rst_en) begin
      n.lv_flag = 1'b1;
    end
    n.lv_irq = n.lv_flag & n.lv_irq_en;
    // Low-voltage part follows the irq line, so wake never lags it
    n.wake = |{n.lv_irq, MODULE_FLAGS & MODULE_IRQ_EN};
    // Reset sequencing
    case (r.state)
      SRWC_RUN: begin
        if (any_src) begin
          n.state = SRWC_HOLD;
          n.hold_lv = POWER_ON_DETECT | src_lv;
          n.cause = 8'h00;
          if (POWER_ON_DETECT) begin
            n.cause[CAUSE_POR] = 1'b1;
            n.cause[CAUSE_LV] = 1'b1;
          end else if (src_lv) begin
            n.cause[CAUSE_LV] = 1'b1;
          end else if (!DEBUG_FORCED_RESET_CMD) begin
            n.cause[CAUSE_PIN] = src_pin;
            n.cause[CAUSE_WD] = src_wd;
            n.cause[CAUSE_BAD_OP] = src_bad_op;
            n.cause[CAUSE_BAD_ADDR] = BAD_ADDRESS;
          end
        end
      end
      SRWC_HOLD: begin
        if (POWER_ON_DETECT) begin
          n.hold_lv = 1'b1;
          n.cause = 8'h00;
          n.cause[CAUSE_POR] = 1'b1;
          n.cause[CAUSE_LV] = 1'b1;
        end
        if (!any_src && !(r.hold_lv && LOW_VOLTAGE_DETECT)) begin
          n.state = SRWC_RUN;
          n.hold_lv = 1'b0;
        end
      end
      default: n.state = SRWC_HOLD;
    endcase
    if (n.state == SRWC_HOLD) begin
      n.wd_en = DEF_WD_EN;
      n.wd_long = DEF_WD_LONG;
      n.pin_en = DEF_PIN_EN;
      n.stop_allow = DEF_STOP_ALLOW;
      n.locked = 1'b0;
      n.lv_en = DEF_LV_EN;
      n.lv_stop_en = DEF_LV_STOP_EN;
      n.lv_rst_en = DEF_LV_RST_EN;
      n.lv_irq_en = DEF_LV_IRQ_EN;
      n.lv_flag = 1'b0;
      n.lv_irq = 1'b0;
      n.wake = 1'b0;
      n.wd_count = '0;
    end
    n.sys_rst = (n.state == SRWC_HOLD);
    n.periph_off = (n.state == SRWC_HOLD);
    n.pins_hiz = (n.state == SRWC_HOLD);
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      r <= '0;
      r.state <= SRWC_HOLD;
      r.hold_lv <= 1'b1;
      r.wreq <= 1'b1;
      r.cause[CAUSE_POR] <= 1'b1;
      r.cause[CAUSE_LV] <= 1'b1;
      r.wd_en <= DEF_WD_EN;
      r.wd_long <= DEF_WD_LONG;
      r.pin_en <= DEF_PIN_EN;
      r.stop_allow <= DEF_STOP_ALLOW;
      r.lv_en <= DEF_LV_EN;
      r.lv_stop_en <= DEF_LV_STOP_EN;
      r.lv_rst_en <= DEF_LV_RST_EN;
      r.lv_irq_en <= DEF_LV_IRQ_EN;
      r.sys_rst <= 1'b1;
      r.periph_off <= 1'b1;
      r.pins_hiz <= 1'b1;
      r.lv_active <= DEF_LV_EN;
      r.boot_addr <= BOOT_FETCH_ADDR;
      r.boot_op <= BOOT_JUMP_OPCODE;
    end else begin
      r <= n;
    end
  end

  always_comb begin
    AVS_READDATA = r.rdata;
    AVS_WAITREQUEST = r.wreq;
    SYSTEM_RESET = r.sys_rst;
    PERIPH_DISABLE = r.periph_off;
    PINS_FORCE_HIZ = r.pins_hiz;
    BOOT_ADDR = r.boot_addr;
    BOOT_OPCODE = r.boot_op;
    WAKE_CPU = r.wake;
    LOW_VOLTAGE_IRQ = r.lv_irq;
    LOW_VOLTAGE_DETECT_ACTIVE = r.lv_active;
  end

endmodule
`default_nettype wire

// [tb/srwc_checker.sv]
`timescale 1ns/1ns
`default_nettype none
module srwc_checker import srwc_pkg::*; (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic POWER_ON_DETECT,
  input wire logic LOW_VOLTAGE_DETECT,
  input wire logic BAD_OPCODE,
  input wire logic BAD_ADDRESS,
  input wire logic DEBUG_FORCED_RESET_CMD,
  input wire logic [EXT_MOD-1:0] MODULE_FLAGS,
  input wire logic [EXT_MOD-1:0] MODULE_IRQ_EN,
  input wire logic SYSTEM_RESET,
  input wire logic PERIPH_DISABLE,
  input wire logic PINS_FORCE_HIZ,
  input wire logic [13:0] BOOT_ADDR,
  input wire logic [7:0] BOOT_OPCODE,
  input wire logic WAKE_CPU,
  input wire logic LOW_VOLTAGE_IRQ
);
  // ----------------
  // Port properties
  // ----------------
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  chk_boot_const: assert property (BOOT_ADDR == 14'h3ffd && BOOT_OPCODE == 8'hbc)
    else $error("boot fetch constants wrong");
  chk_reset_outs: assert property (PERIPH_DISABLE == SYSTEM_RESET && PINS_FORCE_HIZ == SYSTEM_RESET)
    else $error("peripheral or pin state differs from reset");
  chk_por_hold: assert property (POWER_ON_DETECT |=> SYSTEM_RESET)
    else $error("power-on not holding reset");
  chk_src_enter: assert property ((BAD_OPCODE || BAD_ADDRESS || DEBUG_FORCED_RESET_CMD) |=> SYSTEM_RESET)
    else $error("reset source ignored");
  chk_release_por: assert property ($fell(SYSTEM_RESET) |-> !$past(POWER_ON_DETECT))
    else $error("reset left while power-on active");
  chk_lv_hold: assert property ((SYSTEM_RESET && LOW_VOLTAGE_DETECT) |=> SYSTEM_RESET)
    else $error("reset left while low voltage");
  chk_wake_on: assert property ((!SYSTEM_RESET && |(MODULE_FLAGS & MODULE_IRQ_EN)) |=> WAKE_CPU)
    else $error("enabled flag did not wake");
  chk_wake_off: assert property ((!(|(MODULE_FLAGS & MODULE_IRQ_EN)) ##1 !LOW_VOLTAGE_IRQ) |-> !WAKE_CPU)
    else $error("wake without enabled source");
endmodule
bind srwc_top srwc_checker i_chk (.REF_CLK, .SYS_RST, .POWER_ON_DETECT, .LOW_VOLTAGE_DETECT,
  .BAD_OPCODE, .BAD_ADDRESS, .DEBUG_FORCED_RESET_CMD, .MODULE_FLAGS, .MODULE_IRQ_EN,
  .SYSTEM_RESET, .PERIPH_DISABLE, .PINS_FORCE_HIZ, .BOOT_ADDR, .BOOT_OPCODE, .WAKE_CPU,
  .LOW_VOLTAGE_IRQ);
`default_nettype wire

// [tb/srwc_top_tb.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("FAIL %s exp %h got %h", n, e, g); end end
module srwc_top_tb import srwc_pkg::*; ;
  logic clk, rst, rd, wr, pin_n, pod, lvd, bad_op, bad_ad, stop_ex, bg_ex, dbg_allow, dbg_cmd;
  logic dbg_mode, stop_mode, tick, wait_req, sys_reset, periph, hiz, wake, lv_irq, lv_act;
  logic [7:0] addr, boot_op;
  logic [31:0] wdata, rdata, exp_v;
  logic [13:0] boot_a;
  logic [3:0] mflags, mien;
  logic [31:0] expq[$];
  logic [7:0] cause_exp [7] = '{8'h40, 8'h10, 8'h08, 8'h10, 8'h10, 8'h00, 8'h18};
  int n_mismatch = 0;
  int num_checks = 0;
  srwc_top i_dut (.REF_CLK(clk), .SYS_RST(rst), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req),
    .PIN_RESET_N(pin_n), .POWER_ON_DETECT(pod), .LOW_VOLTAGE_DETECT(lvd), .BAD_OPCODE(bad_op),
    .BAD_ADDRESS(bad_ad), .STOP_EXECUTED(stop_ex), .BACKGROUND_EXECUTED(bg_ex),
    .DEBUG_MODE_ALLOW(dbg_allow), .DEBUG_FORCED_RESET_CMD(dbg_cmd), .DEBUG_MODE(dbg_mode),
    .STOP_MODE(stop_mode), .TICK_1KHZ(tick), .MODULE_FLAGS(mflags), .MODULE_IRQ_EN(mien),
    .SYSTEM_RESET(sys_reset), .PERIPH_DISABLE(periph), .PINS_FORCE_HIZ(hiz),
    .BOOT_ADDR(boot_a), .BOOT_OPCODE(boot_op), .WAKE_CPU(wake), .LOW_VOLTAGE_IRQ(lv_irq),
    .LOW_VOLTAGE_DETECT_ACTIVE(lv_act));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ----------------
  // Read monitor
  // ----------------
  always @(posedge clk) begin
    if (rd && wait_req === 1'b0 && expq.size() > 0) begin
      exp_v = expq.pop_front();
      `CHK("readdata", exp_v, rdata)
    end
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (wait_req === 1'b0) break;
    end
    if (i == 50) begin n_mismatch++; test_done(); end
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rdx(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic wait_rst(input logic v);
    int i;
    for (i = 0; i < 500; i++) begin
      @(posedge clk);
      if (sys_reset === v) break;
    end
    if (i == 500) begin n_mismatch++; test_done(); end
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk) tick <= 1'b1;
      repeat (2) @(posedge clk);
      tick <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask
  task automatic wd_fire;
    @(posedge clk) tick <= 1'b1;
    wait_rst(1'b1);
    tick <= 1'b0;
    wait_rst(1'b0);
  endtask
  task automatic src(input int k, input logic v);
    case (k)
      0: pin_n <= !v;
      1: bad_op <= v;
      2: bad_ad <= v;
      3: stop_ex <= v;
      4: bg_ex <= v;
      5: dbg_cmd <= v;
      default: begin bad_op <= v; bad_ad <= v; end
    endcase
  endtask
  // ----------------
  // Main sequence
  // ----------------
  initial begin
    {rst, pod, pin_n} = 3'b111;
    {rd, wr, lvd, bad_op, bad_ad, stop_ex, bg_ex, dbg_allow, dbg_cmd} = '0;
    {dbg_mode, stop_mode, tick, addr, wdata, mflags, mien} = '0;
    void'($urandom(32'hcbb64460));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk) `CHK("held", 1'b1, sys_reset & periph & hiz)
    @(posedge clk) pod <= 1'b0;
    wait_rst(1'b0);
    @(negedge clk) `CHK("boot", {14'h3ffd, 8'hbc}, {boot_a, boot_op})
    rdx(OFS_RESET_CAUSE, 32'h82);
    rdx(OFS_SYS_OPTIONS, 32'h07);
    $display("test reset done");
    ticks(5);
    rdx(OFS_WD_COUNT, 32'h05);
    bus(1'b1, OFS_SYS_OPTIONS, 32'h05);
    rdx(OFS_WD_COUNT, 32'h00);
    bus(1'b1, OFS_SYS_OPTIONS, 32'h00);
    rdx(OFS_SYS_OPTIONS, 32'h85);
    ticks(3);
    dbg_mode <= 1'b1;
    ticks(4);
    rdx(OFS_WD_COUNT, 32'h03);
    dbg_mode <= 1'b0;
    bus(1'b1, OFS_RESET_CAUSE, $urandom);
    rdx(OFS_WD_COUNT, 32'h00);
    rdx(OFS_RESET_CAUSE, 32'h82);
    ticks(2);
    stop_mode <= 1'b1;
    ticks(2);
    rdx(OFS_WD_COUNT, 32'h00);
    stop_mode <= 1'b0;
    ticks(1);
    rdx(OFS_WD_COUNT, 32'h01);
    bus(1'b1, OFS_RESET_CAUSE, 32'h0);
    ticks(31);
    rdx(OFS_WD_COUNT, 32'h1f);
    wd_fire();
    rdx(OFS_RESET_CAUSE, 32'h20);
    ticks(255);
    rdx(OFS_WD_COUNT, 32'hff);
    wd_fire();
    rdx(OFS_RESET_CAUSE, 32'h20);
    $display("test watchdog done");
    for (int k = 0; k < 7; k++) begin
      @(posedge clk) src(k, 1'b1);
      wait_rst(1'b1);
      src(k, 1'b0);
      wait_rst(1'b0);
      rdx(OFS_RESET_CAUSE, {24'h0, cause_exp[k]});
    end
    bus(1'b1, OFS_SYS_OPTIONS, 32'h03);
    @(posedge clk) pin_n <= 1'b0;
    repeat (10) @(posedge clk);
    @(negedge clk) `CHK("pin gated", 1'b0, sys_reset)
    @(posedge clk) pin_n <= 1'b1;
    $display("test sources done");
    @(negedge clk) `CHK("lv active", 1'b1, lv_act)
    @(posedge clk) stop_mode <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk) `CHK("lv stop off", 1'b0, lv_act)
    @(posedge clk) begin stop_mode <= 1'b0; lvd <= 1'b1; end
    wait_rst(1'b1);
    repeat (20) @(posedge clk);
    @(negedge clk) `CHK("lv hold", 1'b1, sys_reset)
    @(posedge clk) lvd <= 1'b0;
    wait_rst(1'b0);
    rdx(OFS_RESET_CAUSE, 32'h02);
    bus(1'b1, OFS_POWER_MON, 32'h0b);
    @(posedge clk) stop_mode <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk) `CHK("lv stop on", 1'b1, lv_act)
    @(posedge clk) begin stop_mode <= 1'b0; lvd <= 1'b1; end
    repeat (3) @(posedge clk);
    lvd <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk) `CHK("lv irq", 3'b011, {sys_reset, lv_irq, wake})
    rdx(OFS_POWER_MON, 32'h1b);
    rdx(OFS_IRQ_PENDING, 32'h10);
    bus(1'b1, OFS_POWER_MON, 32'h2b);
    rdx(OFS_POWER_MON, 32'h0b);
    $display("test lowvolt done");
    repeat (4) begin
      @(posedge clk) begin mflags <= 4'($urandom); mien <= 4'($urandom); end
      repeat (2) @(posedge clk);
      @(negedge clk) `CHK("wake", |(mflags & mien), wake)
      bus(1'b1, OFS_IRQ_PENDING, 32'hff);
      rdx(OFS_IRQ_PENDING, {28'h0, mflags});
    end
    @(posedge clk) mflags <= 4'h0;
    rdx(OFS_IRQ_PENDING, 32'h0);
    rdx(8'h20, 32'h0);
    $display("test pending done");
    @(posedge clk) begin pod <= 1'b1; lvd <= 1'b1; end
    wait_rst(1'b1);
    pod <= 1'b0;
    repeat (10) @(posedge clk);
    @(negedge clk) `CHK("por lv hold", 1'b1, sys_reset)
    @(posedge clk) lvd <= 1'b0;
    wait_rst(1'b0);
    rdx(OFS_RESET_CAUSE, 32'h82);
    $display("test power-on done");
    test_done();
  end
endmodule
`default_nettype wire
